// [core/pmel_core.v]
// power management error log: 64-bit machine-check style status record
// assumes error event pulses come from logic on clk; register port is same-clock
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "pmel_regs.vh"

module pmel_core (
    input  wire                  clk,
    input  wire                  resetn,
    // register port
    input  wire [7:0]            addr,
    input  wire [31:0]           wdata,
    input  wire                  wr,
    input  wire                  rd,
    output reg  [31:0]           rdata,
    // error events, one-cycle pulses, one per source
    input  wire                  err_boot_rst,
    input  wire                  err_ill_msg,
    input  wire                  err_sleep_req,
    input  wire                  err_bad_sx,
    input  wire                  err_vid_mism,
    input  wire                  err_link_trn,
    // attributes of any event in the same cycle; enable and uc are per source, the others shared
    input  wire [`PMEL_NSRC-1:0] per_error_enable,
    input  wire [`PMEL_NSRC-1:0] err_uc,
    input  wire                  err_pcc,
    input  wire                  err_extra_info_valid,
    input  wire                  err_fault_address_valid,
    input  wire [15:0]           err_mca_code,
    // state seen by the rest of the uncore
    output wire                  record_valid,
    output wire                  record_overflow
);

    // ****************************************
    // record state
    // ****************************************
    reg         valid_q;
    reg         over_q;
    reg         uc_q;
    reg         en_q;
    reg         extra_info_valid_q;
    reg         fault_address_valid_q;
    reg         pcc_q;
    reg  [15:0] msc_q;
    reg  [15:0] mca_q;

    wire [`PMEL_NSRC-1:0] req;
    wire [2:0]            pick;
    wire                  any_err;
    wire                  any_uc;
    reg  [15:0]           new_code;
    reg                   new_en;
    reg                   new_uc;
    reg                   replace;
    reg                   clr_rec;
    reg                   clr_over;

    assign req = {err_link_trn, err_vid_mism, err_bad_sx,
                  err_sleep_req, err_ill_msg, err_boot_rst};

    // code table for each source index
    function [15:0] code_of;
        input [2:0] i;
        begin
            case (i)
                3'd0:    code_of = `PMEL_MSC_BOOT_RST;
                3'd1:    code_of = `PMEL_MSC_ILL_MSG;
                3'd2:    code_of = `PMEL_MSC_SLEEP_REQ;
                3'd3:    code_of = `PMEL_MSC_BAD_SX;
                3'd4:    code_of = `PMEL_MSC_VID_MISM;
                3'd5:    code_of = `PMEL_MSC_LINK_TRN;
                default: code_of = `PMEL_MSC_NONE;
            endcase
        end
    endfunction

    pmel_prio u_prio (
        .req    (req),
        .uc_in  (err_uc),
        .idx    (pick),
        .any    (any_err),
        .any_uc (any_uc)
    );

    // ****************************************
    // overwrite decision
    // ****************************************
    // an enabled error beats a disabled one, uncorrected beats corrected,
    // but a held uncorrected error is never displaced
    always @* begin
        new_code = code_of(pick);
        new_en   = per_error_enable[pick];
        new_uc   = any_uc;
        replace  = 1'b0;
        if (any_err) begin
            if (!valid_q) begin
                replace = 1'b1;
            end else if (uc_q) begin
                replace = 1'b0;
            end else if (new_uc) begin
                replace = 1'b1;
            end else if (new_en && !en_q) begin
                replace = 1'b1;
            end
        end
    end

    // ****************************************
    // software clear strobes
    // ****************************************
    // the record itself is read-only; clearing goes through a side register
    always @* begin
        clr_rec  = wr && (addr == `PMEL_OFF_CLEAR) && wdata[`PMEL_CLR_RECORD];
        clr_over = wr && (addr == `PMEL_OFF_CLEAR) &&
                   (wdata[`PMEL_CLR_OVER] || wdata[`PMEL_CLR_RECORD]);
    end

    // ****************************************
    // record update
    // ****************************************
    // a new error in the clear cycle wins over the clear
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            over_q  <= 1'b0;
            uc_q    <= 1'b0;
            en_q    <= 1'b0;
            extra_info_valid_q <= 1'b0;
            fault_address_valid_q <= 1'b0;
            pcc_q   <= 1'b0;
            msc_q   <= `PMEL_MSC_NONE;
            mca_q   <= 16'h0000;
        end else begin
            if (clr_rec) begin
                valid_q <= 1'b0;
                uc_q    <= 1'b0;
                en_q    <= 1'b0;
                extra_info_valid_q <= 1'b0;
                fault_address_valid_q <= 1'b0;
                pcc_q   <= 1'b0;
                msc_q   <= `PMEL_MSC_NONE;
                mca_q   <= 16'h0000;
            end
            if (clr_over) begin
                over_q <= 1'b0;
            end
            if (any_err && valid_q && !clr_rec) begin
                over_q <= 1'b1;
            end
            if (any_err && (replace || clr_rec)) begin
                valid_q <= 1'b1;
                uc_q    <= new_uc;
                en_q    <= new_en;
                extra_info_valid_q <= err_extra_info_valid;
                fault_address_valid_q <= err_fault_address_valid;
                pcc_q   <= err_pcc;
                msc_q   <= new_code;
                mca_q   <= err_mca_code;
            end
        end
    end

    assign record_valid    = valid_q;
    assign record_overflow = over_q;

    // ****************************************
    // read port, data one cycle after the strobe
    // ****************************************
    // writes to the record words fall through untouched
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `PMEL_OFF_REC_LO: rdata <= {msc_q, mca_q};
                `PMEL_OFF_REC_HI: rdata <= {valid_q, over_q, uc_q, en_q,
                                            extra_info_valid_q, fault_address_valid_q, pcc_q,
                                            25'h000_0000};
                default:          rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
    // no write path reaches the record words

endmodule

// [core/pmel_regs.vh]
// register offsets, field positions and error codes of the power error record
// assumes inclusion by bare name from the design files
`ifndef PMEL_REGS_VH
`define PMEL_REGS_VH

// ****************************************
// register map
// ****************************************
`define PMEL_OFF_REC_LO     8'hB0
`define PMEL_OFF_REC_HI     8'hB4
`define PMEL_OFF_CLEAR      8'hB8

// ****************************************
// field positions within the 64-bit record
// ****************************************
`define PMEL_BIT_VALID      63
`define PMEL_BIT_OVER       62
`define PMEL_BIT_UC         61
`define PMEL_BIT_EN         60
`define PMEL_BIT_EXTRA_INFO_VALID      59
`define PMEL_BIT_FAULT_ADDRESS_VALID      58
`define PMEL_BIT_PCC        57
`define PMEL_MSC_HI         31
`define PMEL_MSC_LO         16
`define PMEL_MCA_HI         15
`define PMEL_MCA_LO         0

// clear register: bit 1 clears overflow, bit 0 clears the whole record
`define PMEL_CLR_RECORD     0
`define PMEL_CLR_OVER       1

// ****************************************
// model specific error codes
// ****************************************
`define PMEL_MSC_NONE       16'h0000
`define PMEL_MSC_BOOT_RST   16'h0300
`define PMEL_MSC_ILL_MSG    16'h0800
`define PMEL_MSC_SLEEP_REQ  16'h0A00
`define PMEL_MSC_BAD_SX     16'h0D00
`define PMEL_MSC_VID_MISM   16'h1100
`define PMEL_MSC_LINK_TRN   16'h1A00

// number of error sources and reset value of the record
`define PMEL_NSRC           6
`define PMEL_REC_RESET      64'h0000_0000_0000_0000

`endif

// [core/pmel_prio.v]
// priority pick among simultaneous error sources, lowest uncorrected index wins, else lowest index
// assumes one-hot-or-zero masking is not required of the caller
`timescale 1ns/1ps
`include "pmel_regs.vh"

module pmel_prio (
    input  wire [`PMEL_NSRC-1:0] req,
    input  wire [`PMEL_NSRC-1:0] uc_in,
    output reg  [2:0]            idx,
    output reg                   any,
    output reg                   any_uc
);
    integer i;

    // ****************************************
    // pick the first uncorrected source, else the first source
    // ****************************************
    // uncorrected sources are preferred so a same-cycle uc error is kept
    always @* begin
        idx    = 3'd0;
        any    = 1'b0;
        any_uc = 1'b0;
        for (i = `PMEL_NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && !any_uc) begin
                idx = i[2:0];
                any = 1'b1;
            end
        end
        for (i = `PMEL_NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && uc_in[i]) begin
                idx    = i[2:0];
                any_uc = 1'b1;
            end
        end
    end
endmodule

// [dv/pmel_core_checker.sv]
// port checker for the power error record
// assumes it is bound onto pmel_core, one clock, async low reset
`timescale 1ns/1ps
`include "pmel_regs.vh"
// ****************************************
// checker
// ****************************************
// ports grouped per line to keep the checker short
module pmel_core_checker (
    input wire        clk, resetn, wr, rd,
    input wire [7:0]  addr,
    input wire [31:0] wdata, rdata,
    input wire        err_boot_rst, err_ill_msg, err_sleep_req,
    input wire        err_bad_sx, err_vid_mism, err_link_trn,
    input wire [5:0]  per_error_enable, err_uc,
    input wire        err_pcc, err_extra_info_valid, err_fault_address_valid,
    input wire [15:0] err_mca_code,
    input wire        record_valid, record_overflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // any event or clear write this cycle
    wire ev  = err_boot_rst | err_ill_msg | err_sleep_req | err_bad_sx | err_vid_mism
             | err_link_trn;
    wire clr = wr && addr == `PMEL_OFF_CLEAR;
    wire hi  = rd && addr == `PMEL_OFF_REC_HI;
    a_event_logged: assert property (ev |=> record_valid)
        else $error("event not logged");
    a_valid_cause: assert property (!ev && !record_valid |=> !record_valid)
        else $error("valid rose without event");
    // a record clear in the event cycle logs the event fresh, with no overflow
    a_over_set: assert property (ev && record_valid && !(clr && wdata[0]) |=> record_overflow)
        else $error("overflow missed");
    a_over_cause: assert property (!ev && !record_overflow |=> !record_overflow)
        else $error("overflow rose without event");
    a_over_sticky: assert property (record_overflow && !clr |=> record_overflow)
        else $error("overflow lost");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
        else $error("rdata not zero");
    // record cannot move in the read cycle without an event, so compare live flags
    a_hi_fields: assert property (hi && !ev |=> rdata[31:30] == {record_valid,
        record_overflow} && rdata[24:0] == 25'h000_0000)
        else $error("high word wrong");
    a_unmapped_zero: assert property (rd && addr > `PMEL_OFF_CLEAR |=> rdata == 0)
        else $error("unmapped read not zero");
    c_overflow: cover property (ev && record_valid);
    c_read_hi: cover property (hi && record_valid);
    c_clear_over: cover property (clr && record_overflow);
endmodule
bind pmel_core pmel_core_checker i_pmel_core_checker (.clk, .resetn, .wr, .rd, .addr,
    .wdata, .rdata, .err_boot_rst, .err_ill_msg, .err_sleep_req, .err_bad_sx, .err_vid_mism,
    .err_link_trn, .per_error_enable, .err_uc, .err_pcc, .err_extra_info_valid, .err_fault_address_valid,
    .err_mca_code, .record_valid, .record_overflow);

// [dv/pmel_core_bench.sv]
// self-checking bench for the power error record
// assumes pmel_core alone; reads answer one cycle after the strobe
`timescale 1ns/1ps
`include "pmel_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
// ****************************************
// bench top
// ****************************************
module pmel_core_bench;
    reg          clk = 0, resetn = 0, wr = 0, rd = 0, rd_seen = 0;
    reg  [7:0]   addr = 0;
    reg  [31:0]  wdata = 0;
    reg  [5:0]   ev = 0, en = 0, uc = 0;
    reg  [2:0]   fl = 0;
    reg  [15:0]  mca = 0;
    wire [31:0]  rdata;
    wire         vld, ovr;
    logic [31:0] q[$];
    logic [31:0] exp_v;
    logic [15:0] code [6] = '{`PMEL_MSC_BOOT_RST, `PMEL_MSC_ILL_MSG, `PMEL_MSC_SLEEP_REQ,
                              `PMEL_MSC_BAD_SX, `PMEL_MSC_VID_MISM, `PMEL_MSC_LINK_TRN};
    int          n_errors = 0, comparisons = 0;
    pmel_core i_pmel_core (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
        .err_boot_rst(ev[0]), .err_ill_msg(ev[1]), .err_sleep_req(ev[2]), .err_bad_sx(ev[3]),
        .err_vid_mism(ev[4]), .err_link_trn(ev[5]), .per_error_enable(en), .err_uc(uc),
        .err_extra_info_valid(fl[2]), .err_fault_address_valid(fl[1]), .err_pcc(fl[0]), .err_mca_code(mca),
        .record_valid(vld), .record_overflow(ovr));
    initial forever #50 clk = ~clk;
    // monitor: the oldest note is due one cycle after each read strobe
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen) begin
            exp_v = q.size() ? q.pop_front() : 32'hxxxx_xxxx;
            `CHK("rdata", exp_v, rdata)
        end
    end
    task automatic wr_reg(input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input [7:0] a, input [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        q.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask
    // one-cycle event with its attributes in the same cycle
    task automatic err(input int s, input [5:0] u, input [5:0] e, input [2:0] f,
                       input [15:0] m);
        @(posedge clk);
        ev <= 6'h01 << s;
        uc <= u;
        en <= e;
        fl <= f;
        mca <= m;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    function automatic [31:0] hi(input o, input u, input e, input [2:0] f);
        hi = {1'b1, o, u, e, f, 25'h000_0000};
    endfunction
    initial begin
        int s;
        logic [5:0] u, e;
        logic [2:0] f;
        logic [15:0] m;
        void'($urandom(97));
        repeat (5) @(posedge clk);
        resetn <= 1;
        rd_reg(`PMEL_OFF_REC_LO, 32'h0000_0000);
        rd_reg(`PMEL_OFF_REC_HI, 32'h0000_0000);
        rd_reg(8'h00_C0, 32'h0000_0000);
        // every source once, random attributes, software writes to the record words are ignored
        for (s = 0; s < 6; s++) begin
            u = $urandom;
            e = $urandom;
            f = $urandom;
            m = $urandom;
            wr_reg(`PMEL_OFF_CLEAR, 32'h0000_0001);
            rd_reg(`PMEL_OFF_REC_LO, {`PMEL_MSC_NONE, 16'h0000});
            err(s, u, e, f, m);
            wr_reg(`PMEL_OFF_REC_LO, $urandom);
            wr_reg(`PMEL_OFF_REC_HI, $urandom);
            rd_reg(`PMEL_OFF_REC_LO, {code[s], m});
            rd_reg(`PMEL_OFF_REC_HI, hi(0, u[s], e[s], f));
        end
        // overwrite priority: enabled over disabled, uncorrected kept
        wr_reg(`PMEL_OFF_CLEAR, 32'h0000_0001);
        err(1, 6'h00, 6'h00, 3'h0, 16'h1111);
        err(2, 6'h00, 6'h04, 3'h0, 16'h2222);
        rd_reg(`PMEL_OFF_REC_LO, {`PMEL_MSC_SLEEP_REQ, 16'h2222});
        rd_reg(`PMEL_OFF_REC_HI, hi(1, 0, 1, 3'h0));
        `CHK("record_overflow", 1'b1, ovr)
        err(3, 6'h08, 6'h08, 3'h0, 16'h3333);
        err(4, 6'h10, 6'h10, 3'h0, 16'h4444);
        rd_reg(`PMEL_OFF_REC_LO, {`PMEL_MSC_BAD_SX, 16'h3333});
        wr_reg(`PMEL_OFF_CLEAR, 32'h0000_0002);
        rd_reg(`PMEL_OFF_REC_HI, hi(0, 1, 1, 3'h0));
        `CHK("record_overflow", 1'b0, ovr)
        `CHK("record_valid", 1'b1, vld)
        // bounded drain of outstanding reads
        for (s = 0; s < 10 && q.size() > 0; s++) @(posedge clk);
        if (q.size() > 0) n_errors++;
        stop_test;
    end
    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
endmodule
